// ---- logic/wake_pkg.sv ----
// Behaviour
// - three independent wake channels with own paths
// - rising and falling edges both make events
// - event interrupts in normal/stop, wakes otherwise
// - static sense continuous, cyclic only in window
// - cyclic window from timer one or two
// - static filter selectable sixteen or sixty-four us
// - event only if input stable whole filter time
// - per-pin wake enable control bits
// - per-pin sticky wake source flags readable
// - level status readable in normal and stop
// - cyclic sense shows level sampled in window
// - fail-output pins: fixed short filter, alt status
// - two-bit filter select field encoding
// - two-bit pull select field, automatic follows level
package wake_pkg;
    localparam int          CLK_MHZ           = 25;
    localparam int          SHORT_FILTER_US   = 16;
    localparam int          LONG_FILTER_US    = 64;
    localparam int          SHORT_FILTER_CYC  = SHORT_FILTER_US * CLK_MHZ;
    localparam int          LONG_FILTER_CYC   = LONG_FILTER_US * CLK_MHZ;
    localparam int          FILTER_CNT_W      = 11;
    localparam int          NUM_WAKE          = 3;
    localparam int          NUM_ALT           = 2;
    localparam logic [1:0]  FLT_STATIC_SHORT  = 2'h0;
    localparam logic [1:0]  FLT_STATIC_LONG   = 2'h1;
    localparam logic [1:0]  FLT_CYCLIC_ONE    = 2'h2;
    localparam logic [1:0]  FLT_CYCLIC_TWO    = 2'h3;
    localparam logic [1:0]  PULL_NONE         = 2'h0;
    localparam logic [1:0]  PULL_DOWN         = 2'h1;
    localparam logic [1:0]  PULL_UP           = 2'h2;
    localparam logic [1:0]  PULL_AUTO         = 2'h3;
    localparam logic [1:0]  MODE_NORMAL       = 2'h0;
    localparam logic [1:0]  MODE_STOP         = 2'h1;
    localparam logic [1:0]  MODE_SLEEP        = 2'h2;
    localparam logic [1:0]  MODE_FAIL_SAFE    = 2'h3;
    typedef enum logic [1:0] {
        CH_IDLE   = 2'b01,
        CH_FILTER = 2'b10
    } ch_state_t;
endpackage : wake_pkg

// ---- logic/wake_channel.sv ----
`timescale 1ns/1ps
module wake_channel
    import wake_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_FILTER_CYC,
    parameter int LONG_CYC  = LONG_FILTER_CYC
) (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    input  wire logic active_in,
    input  wire logic long_in,
    output logic      event_out,
    output logic      level_out
);
    logic                    sync_a;
    logic                    sync_b;
    logic                    stable;
    logic [FILTER_CNT_W-1:0] count;
    ch_state_t               state;
    ch_state_t               next_state;
    wire  [FILTER_CNT_W-1:0] limit   = long_in ? FILTER_CNT_W'(LONG_CYC - 1) : FILTER_CNT_W'(SHORT_CYC - 1);
    wire                     changed = active_in && (sync_b != stable);
    wire                     expired = (count >= limit);

    always_comb begin
        next_state = state;
        case (state)
            CH_IDLE:   if (changed) next_state = CH_FILTER;
            CH_FILTER: begin
                if (!active_in || !changed) next_state = CH_IDLE;
                else if (expired) next_state = CH_IDLE;
            end
            default:   next_state = CH_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        sync_a <= pin_in;
        sync_b <= sync_a;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state     <= CH_IDLE;
            count     <= '0;
            stable    <= 1'b0;
            event_out <= 1'b0;
            level_out <= 1'b0;
        end else begin
            state     <= next_state;
            count     <= (state == CH_FILTER && changed) ? count + 1'b1 : '0;
            event_out <= (state == CH_FILTER) && changed && expired;
            if (state == CH_FILTER && changed && expired) stable <= sync_b;
            if (active_in) level_out <= sync_b;
        end
    end
endmodule : wake_channel

// ---- logic/wake_input_detector.sv ----
`timescale 1ns/1ps
module wake_input_detector
    import wake_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_FILTER_CYC,
    parameter int LONG_CYC  = LONG_FILTER_CYC
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  wire logic [NUM_WAKE-1:0]   wake_pin_in,
    input  wire logic [NUM_ALT-1:0]    fail_output_pins_in,
    input  wire logic                  alt_wake_mode_in,
    input  wire logic [1:0]            device_mode_in,
    input  wire logic                  cyclic_timer_one_in,
    input  wire logic                  cyclic_timer_two_in,
    input  wire logic [2*NUM_WAKE-1:0] wake_filter_select_in,
    input  wire logic [2*NUM_WAKE-1:0] wake_pull_select_in,
    input  wire logic [NUM_WAKE-1:0]   wake_enable_control_in,
    input  wire logic [NUM_WAKE-1:0]   wake_source_clear_in,
    input  wire logic [NUM_ALT-1:0]    alt_wake_source_clear_in,
    output logic [NUM_WAKE-1:0]        wake_source_status_out,
    output logic [NUM_ALT-1:0]         alt_wake_source_status_out,
    output logic [NUM_WAKE-1:0]        wake_level_status_out,
    output logic [NUM_WAKE-1:0]        pull_up_en_out,
    output logic [NUM_WAKE-1:0]        pull_down_en_out,
    output logic                       interrupt_out,
    output logic                       wake_up_out
);
    logic [NUM_WAKE-1:0] ch_event;
    logic [NUM_WAKE-1:0] ch_level;
    logic [NUM_WAKE-1:0] ch_active;
    logic [NUM_WAKE-1:0] ch_long;
    logic [NUM_ALT-1:0]  alt_event;
    wire                 awake_mode  = (device_mode_in == MODE_NORMAL) || (device_mode_in == MODE_STOP);
    wire [NUM_WAKE-1:0]  wake_hits   = ch_event & wake_enable_control_in;
    wire [NUM_ALT-1:0]   alt_hits    = alt_event & {NUM_ALT{alt_wake_mode_in}};
    wire                 any_event   = (|wake_hits) || (|alt_hits);
    logic [NUM_WAKE-1:0] next_pull_up;
    logic [NUM_WAKE-1:0] next_pull_down;

    always_comb begin
        for (int i = 0; i < NUM_WAKE; i++) begin
            case (wake_filter_select_in[2*i +: 2])
                FLT_STATIC_SHORT: begin ch_active[i] = 1'b1; ch_long[i] = 1'b0; end
                FLT_STATIC_LONG:  begin ch_active[i] = 1'b1; ch_long[i] = 1'b1; end
                FLT_CYCLIC_ONE:   begin ch_active[i] = cyclic_timer_one_in; ch_long[i] = 1'b0; end
                FLT_CYCLIC_TWO:   begin ch_active[i] = cyclic_timer_two_in; ch_long[i] = 1'b0; end
                default:          begin ch_active[i] = 1'b1; ch_long[i] = 1'b0; end
            endcase
            case (wake_pull_select_in[2*i +: 2])
                PULL_DOWN: begin next_pull_up[i] = 1'b0; next_pull_down[i] = 1'b1; end
                PULL_UP:   begin next_pull_up[i] = 1'b1; next_pull_down[i] = 1'b0; end
                PULL_AUTO: begin next_pull_up[i] = ch_level[i]; next_pull_down[i] = !ch_level[i]; end
                default:   begin next_pull_up[i] = 1'b0; next_pull_down[i] = 1'b0; end
            endcase
        end
    end

    for (genvar g = 0; g < NUM_WAKE; g++) begin : g_wake
        wake_channel #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_ch (
            .core_clk_in (core_clk_in),
            .rst_in      (rst_in),
            .pin_in      (wake_pin_in[g]),
            .active_in   (ch_active[g]),
            .long_in     (ch_long[g]),
            .event_out   (ch_event[g]),
            .level_out   (ch_level[g])
        );
    end

    for (genvar g = 0; g < NUM_ALT; g++) begin : g_alt
        wake_channel #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_alt (
            .core_clk_in (core_clk_in),
            .rst_in      (rst_in),
            .pin_in      (fail_output_pins_in[g]),
            .active_in   (1'b1),
            .long_in     (1'b0),
            .event_out   (alt_event[g]),
            .level_out   ()
        );
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wake_source_status_out     <= '0;
            alt_wake_source_status_out <= '0;
            wake_level_status_out      <= '0;
            pull_up_en_out             <= '0;
            pull_down_en_out           <= '0;
            interrupt_out              <= 1'b0;
            wake_up_out                <= 1'b0;
        end else begin
            // set wins over clear
            wake_source_status_out     <= (wake_source_status_out & ~wake_source_clear_in) | wake_hits;
            alt_wake_source_status_out <= (alt_wake_source_status_out & ~alt_wake_source_clear_in) | alt_hits;
            if (awake_mode) wake_level_status_out <= ch_level;
            pull_up_en_out             <= next_pull_up;
            pull_down_en_out           <= next_pull_down;
            interrupt_out              <= any_event && awake_mode;
            wake_up_out                <= any_event && !awake_mode;
        end
    end
endmodule : wake_input_detector

// ---- dv/wake_asserts.sv ----
`timescale 1ns/1ps
module wake_asserts
    import wake_pkg::*;
(
    input wire logic                  core_clk_in,
    input wire logic                  rst_in,
    input wire logic [1:0]            device_mode_in,
    input wire logic [2*NUM_WAKE-1:0] wake_pull_select_in,
    input wire logic [NUM_WAKE-1:0]   wake_enable_control_in,
    input wire logic [NUM_WAKE-1:0]   wake_source_clear_in,
    input wire logic [NUM_WAKE-1:0]   wake_source_status_out,
    input wire logic [NUM_ALT-1:0]    alt_wake_source_status_out,
    input wire logic [NUM_WAKE-1:0]   wake_level_status_out,
    input wire logic [NUM_WAKE-1:0]   pull_up_en_out,
    input wire logic [NUM_WAKE-1:0]   pull_down_en_out,
    input wire logic                  interrupt_out,
    input wire logic                  wake_up_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_irq_mode; interrupt_out |-> !$past(device_mode_in[1]) && !wake_up_out; endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("interrupt outside normal or stop");
    property p_wake_mode; wake_up_out |-> $past(device_mode_in[1]); endproperty
    a_wake_mode: assert property (p_wake_mode) else $error("wake outside sleep or fail-safe");
    property p_new_flag; (wake_source_status_out & ~$past(wake_source_status_out)) != 0 |-> interrupt_out || wake_up_out; endproperty
    a_new_flag: assert property (p_new_flag) else $error("flag set without event pulse");
    property p_sticky; (wake_source_status_out & ~wake_source_clear_in) != 0 |=> ($past(wake_source_status_out & ~wake_source_clear_in) & ~wake_source_status_out) == 0; endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
    property p_enable; (wake_source_status_out & ~$past(wake_source_status_out) & ~$past(wake_enable_control_in)) == 0; endproperty
    a_enable: assert property (p_enable) else $error("flag set on disabled pin");
    property p_frozen; device_mode_in[1] && $past(device_mode_in[1]) |-> $stable(wake_level_status_out); endproperty
    a_frozen: assert property (p_frozen) else $error("level changed in sleep");
    property p_pulse_flag; interrupt_out || wake_up_out |-> |{wake_source_status_out, alt_wake_source_status_out}; endproperty
    a_pulse_flag: assert property (p_pulse_flag) else $error("event pulse without flag");
    property p_pull; ^wake_pull_select_in[1:0] |=> pull_up_en_out[0] == $past(wake_pull_select_in[1]) && pull_down_en_out[0] == $past(wake_pull_select_in[0]); endproperty
    a_pull: assert property (p_pull) else $error("fixed pull mismatch");
endmodule : wake_asserts
bind wake_input_detector wake_asserts wake_asserts_inst (.core_clk_in, .rst_in, .device_mode_in, .wake_pull_select_in,
    .wake_enable_control_in, .wake_source_clear_in, .wake_source_status_out, .alt_wake_source_status_out,
    .wake_level_status_out, .pull_up_en_out, .pull_down_en_out, .interrupt_out, .wake_up_out);

// ---- dv/wake_switch_model.sv ----
`timescale 1ns/1ps
module wake_switch_model (
    input  wire logic       core_clk_in,
    input  wire logic [2:0] target_in,
    input  wire logic [1:0] alt_target_in,
    output logic      [2:0] pin_out = 3'h0,
    output logic      [1:0] alt_pin_out = 2'h0
);
    // contacts settle one cycle after the command
    always_ff @(posedge core_clk_in) begin
        pin_out     <= target_in;
        alt_pin_out <= alt_target_in;
    end
endmodule : wake_switch_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import wake_pkg::*;
    localparam int SH = 8;
    localparam int LG = 32;
    logic clk = 1'b0, rst = 1'b1, am = 1'b0, t1 = 1'b0, t2 = 1'b0, irq, wk;
    logic [2:0] tgt = 3'h0, pin, en = 3'h7, clr = 3'h0, src, lvl, pu, pd;
    logic [1:0] fo = 2'h0, afo, aclr = 2'h0, mode = 2'h0, asrc;
    logic [5:0] flt = 6'h00, pull = 6'h00;
    int err_count = 0, cmp_count = 0, irqs = 0, wks = 0;
    wake_switch_model wake_switch_model_inst (.core_clk_in(clk), .target_in(tgt), .alt_target_in(fo),
        .pin_out(pin), .alt_pin_out(afo));
    wake_input_detector #(.SHORT_CYC(SH), .LONG_CYC(LG)) wake_input_detector_inst (.core_clk_in(clk), .rst_in(rst),
        .wake_pin_in(pin), .fail_output_pins_in(afo), .alt_wake_mode_in(am), .device_mode_in(mode),
        .cyclic_timer_one_in(t1), .cyclic_timer_two_in(t2), .wake_filter_select_in(flt), .wake_pull_select_in(pull),
        .wake_enable_control_in(en), .wake_source_clear_in(clr), .alt_wake_source_clear_in(aclr),
        .wake_source_status_out(src), .alt_wake_source_status_out(asrc), .wake_level_status_out(lvl),
        .pull_up_en_out(pu), .pull_down_en_out(pd), .interrupt_out(irq), .wake_up_out(wk));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        irqs += (irq === 1'b1);
        wks += (wk === 1'b1);
    end
    task automatic step(int n);
        repeat (n) @(posedge clk);
    endtask : step
    function automatic int fwait(logic [1:0] f);
        return ((f == FLT_STATIC_LONG) ? LG : SH) + 8;
    endfunction : fwait
    task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic clear();
        clr <= 3'h7;
        aclr <= 2'h3;
        step(1);
        clr <= 3'h0;
        aclr <= 2'h0;
        step(1);
    endtask : clear
    task automatic stop_test();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    initial begin
        step(5000);
        err_count++;
        stop_test();
    end
    initial begin
        int i;
        void'($urandom(46));
        step(5);
        rst <= 0;
        step(1);
        chk("flags", 0, src);
        repeat (12) begin
            i = $urandom_range(2, 0);
            tgt[i] <= ~tgt[i];
            step(fwait(flt[2*i+:2]));
            chk("flags", 4'h1 << i, src);
            chk("level", tgt, lvl);
            clear();
        end
        chk("irq count", 4'hc, irqs[3:0]);
        tgt[0] <= ~tgt[0];
        step(SH - 4);
        tgt[0] <= ~tgt[0];
        step(fwait(0));
        chk("glitch", 0, src);
        flt <= {4'h0, FLT_STATIC_LONG};
        tgt[0] <= ~tgt[0];
        step(SH + 6);
        tgt[0] <= ~tgt[0];
        step(fwait(FLT_STATIC_LONG));
        chk("long glitch", 0, src);
        tgt[0] <= ~tgt[0];
        step(fwait(FLT_STATIC_LONG));
        chk("long", 1, src);
        clear();
        flt <= 0;
        en <= 6;
        tgt[0] <= ~tgt[0];
        step(fwait(0));
        chk("disabled", 0, src);
        chk("disabled irq", 4'hd, irqs[3:0]);
        chk("level", tgt, lvl);
        en <= 7;
        mode <= MODE_SLEEP;
        tgt[1] <= ~tgt[1];
        step(fwait(0));
        chk("sleep flag", 2, src);
        chk("wake count", 1, wks[3:0]);
        chk("frozen", {tgt[2], ~tgt[1], tgt[0]}, lvl);
        mode <= MODE_NORMAL;
        clear();
        flt <= {FLT_CYCLIC_TWO, FLT_CYCLIC_ONE, FLT_STATIC_SHORT};
        tgt[2:1] <= ~tgt[2:1];
        step(fwait(0));
        chk("closed window", 0, src);
        t1 <= 1;
        step(fwait(0));
        chk("timer one", 2, src);
        t2 <= 1;
        step(fwait(0));
        chk("timer two", 6, src);
        t1 <= 0;
        tgt[1] <= ~tgt[1];
        step(fwait(0));
        chk("cyclic level", {3'h0, ~tgt[1]}, {3'h0, lvl[1]});
        am <= 1'b1;
        fo <= 2'h2;
        mode <= MODE_STOP;
        step(fwait(0));
        chk("alt flags", 2, asrc);
        chk("stop irq", 4'h8, 4'(irqs - 8));
        mode <= MODE_FAIL_SAFE;
        tgt[2] <= ~tgt[2];
        step(fwait(0));
        chk("fail-safe wake", 4'h2, wks[3:0]);
        pull <= {PULL_NONE, PULL_UP, PULL_DOWN};
        step(2);
        chk("pull up", 2, pu);
        chk("pull down", 1, pd);
        pull <= {3{PULL_AUTO}};
        step(2);
        chk("auto up", {1'b0, tgt[2], ~tgt[1], tgt[0]}, pu);
        chk("auto down", {1'b0, ~tgt[2], tgt[1], ~tgt[0]}, pd);
        stop_test();
    end
endmodule : tb_top
